// [logic/iocmd_interp.sv]
`timescale 1ns/1ps
`include "iocmd_defs.svh"
module iocmd_interp (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire iocmd_pkg::iocmd_rx_t  rx,
   output logic                       rx_ready,
   output iocmd_pkg::iocmd_tx_t       tx,
   input  wire logic                  tx_ready,
   output iocmd_pkg::iocmd_req_t      reg_req,
   input  wire iocmd_pkg::iocmd_rsp_t reg_rsp
);
   import iocmd_pkg::*;

   iocmd_ctl_t  ctl_ff;
   iocmd_ctl_t  nxt_ctl;
   iocmd_kind_t cmd_kind;
   logic        cmd_legal;
   logic        cmd_wr;
   logic [15:0] exp_len;
   logic        fits;
   logic [7:0]  chk_err;
   logic [255:0] mem;
   logic        clr;
   logic        byte_we;
   logic [4:0]  byte_idx;
   logic        word_we;
   logic        bit_we;
   logic        restart;
   logic [8:0]  pos;
   logic [8:0]  poff;
   logic        tload;
   logic [5:0]  ti;
   logic [5:0]  rlen;
   logic [15:0] nidx;

   // operation decode of the held command code
   always_comb begin
      cmd_kind  = KIND_HOLD;
      cmd_legal = 1'b1;
      cmd_wr    = 1'b0;
      case (ctl_ff.cmd)
         `IOCMD_OP_RD_COIL: cmd_kind = KIND_COIL;
         `IOCMD_OP_RD_HOLD: cmd_kind = KIND_HOLD;
         `IOCMD_OP_RD_INP:  cmd_kind = KIND_INP;
         `IOCMD_OP_WR_COIL: begin
            cmd_kind = KIND_COIL;
            cmd_wr   = 1'b1;
         end
         `IOCMD_OP_WR_HOLD: cmd_wr = 1'b1;
         default:           cmd_legal = 1'b0;
      endcase
   end

   iocmd_len_calc u_len (
      .kind   (cmd_kind),
      .count  (ctl_ff.count),
      .nbytes (exp_len),
      .fits   (fits)
   );

   // request checks, first failing check gives the code
   always_comb begin
      chk_err = `IOCMD_ERR_NONE;
      if (!cmd_legal) begin
         chk_err = `IOCMD_ERR_FUNC;
      end else if (!fits) begin
         chk_err = `IOCMD_ERR_VALUE;
      end else if (cmd_wr && (ctl_ff.nrx < `IOCMD_POS_DATA
                   || {8'h00, ctl_ff.dlen} != exp_len
                   || ctl_ff.nrx != {1'b0, ctl_ff.dlen} + `IOCMD_POS_DATA))
      begin
         chk_err = `IOCMD_ERR_VALUE;
      end else if (!cmd_wr && ctl_ff.nrx != `IOCMD_RD_BYTES) begin
         chk_err = `IOCMD_ERR_VALUE;
      end else if ({1'b0, ctl_ff.start} + {1'b0, ctl_ff.count}
                   > `IOCMD_ADDR_TOP) begin
         chk_err = `IOCMD_ERR_ADDR;
      end
   end

   // write value of register ix taken from the payload
   function automatic logic [15:0] word_at(input logic [15:0] ix);
      if (!cmd_wr) begin
         return 16'h0000;
      end
      if (cmd_kind == KIND_COIL) begin
         return {15'h0000, mem[ix[7:0]]};
      end
      return {mem[{ix[3:0], 4'h0} +: 8], mem[{ix[3:0], 4'h8} +: 8]};
   endfunction

   // response length for error code e
   function automatic logic [5:0] resp_len(input logic [7:0] e);
      if (e != `IOCMD_ERR_NONE) begin
         return `IOCMD_RESP_ERR;
      end
      if (cmd_wr) begin
         return `IOCMD_RESP_WR;
      end
      return `IOCMD_RESP_HDR + exp_len[5:0];
   endfunction

   // response byte i for error code e
   function automatic logic [7:0] resp_byte(input logic [5:0] i,
                                            input logic [7:0] e);
      logic [5:0] k;
      k = i - `IOCMD_RESP_HDR;
      if (i == 6'h00) begin
         return (e != `IOCMD_ERR_NONE) ? (ctl_ff.cmd | `IOCMD_ERR_FLAG)
                                       : ctl_ff.cmd;
      end
      if (e != `IOCMD_ERR_NONE) begin
         return e;
      end
      if (cmd_wr) begin
         unique case (i)
            6'h01:   return ctl_ff.start[15:8];
            6'h02:   return ctl_ff.start[7:0];
            6'h03:   return ctl_ff.count[15:8];
            default: return ctl_ff.count[7:0];
         endcase
      end
      if (i == 6'h01) begin
         return exp_len[7:0];
      end
      return mem[{k[4:0], 3'h0} +: 8];
   endfunction

   // next state of the interpreter
   always_comb begin
      nxt_ctl  = ctl_ff;
      clr      = 1'b0;
      byte_we  = 1'b0;
      byte_idx = 5'h00;
      word_we  = 1'b0;
      bit_we   = 1'b0;
      restart  = 1'b0;
      pos      = 9'h000;
      poff     = 9'h000;
      tload    = 1'b0;
      ti       = 6'h00;
      rlen     = 6'h00;
      nidx     = ctl_ff.idx + 16'h0001;
      unique case (ctl_ff.st)
         ST_IDLE, ST_RX: begin
            if (rx.valid && rx_ready) begin
               restart = (ctl_ff.st == ST_IDLE) || rx.sof;
               pos     = restart ? 9'h000 : ctl_ff.nrx;
               poff    = pos - `IOCMD_POS_DATA;
               if (restart) begin
                  nxt_ctl.start = 16'h0000;
                  nxt_ctl.count = 16'h0000;
                  nxt_ctl.dlen  = 8'h00;
               end
               nxt_ctl.nrx = (pos == `IOCMD_POS_SAT) ? pos : pos + 9'h001;
               unique case (pos)
                  9'h000:  nxt_ctl.cmd = rx.data;
                  9'h001:  nxt_ctl.start[15:8] = rx.data;
                  9'h002:  nxt_ctl.start[7:0] = rx.data;
                  9'h003:  nxt_ctl.count[15:8] = rx.data;
                  9'h004:  nxt_ctl.count[7:0] = rx.data;
                  9'h005:  nxt_ctl.dlen = rx.data;
                  default: begin
                     byte_we  = (poff < `IOCMD_BUF_LIM);
                     byte_idx = poff[4:0];
                  end
               endcase
               nxt_ctl.st = rx.last ? ST_CHECK : ST_RX;
            end
         end
         ST_CHECK: begin
            nxt_ctl.err = chk_err;
            nxt_ctl.idx = 16'h0000;
            if (chk_err != `IOCMD_ERR_NONE) begin
               tload      = 1'b1;
               nxt_ctl.st = ST_RESP;
            end else begin
               clr               = !cmd_wr;
               nxt_ctl.req.valid = 1'b1;
               nxt_ctl.req.wr    = cmd_wr;
               nxt_ctl.req.kind  = cmd_kind;
               nxt_ctl.req.addr  = ctl_ff.start;
               nxt_ctl.req.wdata = word_at(16'h0000);
               nxt_ctl.st        = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (ctl_ff.req.valid && reg_rsp.ack) begin
               if (reg_rsp.err_addr) begin
                  nxt_ctl.err       = `IOCMD_ERR_ADDR;
                  nxt_ctl.req.valid = 1'b0;
                  tload             = 1'b1;
                  nxt_ctl.st        = ST_RESP;
               end else if (reg_rsp.fail) begin
                  nxt_ctl.err       = `IOCMD_ERR_FAIL;
                  nxt_ctl.req.valid = 1'b0;
                  tload             = 1'b1;
                  nxt_ctl.st        = ST_RESP;
               end else begin
                  bit_we  = !ctl_ff.req.wr && cmd_kind == KIND_COIL;
                  word_we = !ctl_ff.req.wr && cmd_kind != KIND_COIL;
                  if (nidx == ctl_ff.count) begin
                     nxt_ctl.req.valid = 1'b0;
                     tload             = 1'b1;
                     nxt_ctl.st        = ST_RESP;
                  end else begin
                     nxt_ctl.idx       = nidx;
                     nxt_ctl.req.addr  = ctl_ff.start + nidx;
                     nxt_ctl.req.wdata = word_at(nidx);
                  end
               end
            end
         end
         ST_RESP: begin
            if (ctl_ff.tx.valid && tx_ready) begin
               if (ctl_ff.tx.last) begin
                  nxt_ctl.tx.valid = 1'b0;
                  nxt_ctl.tx.last  = 1'b0;
                  nxt_ctl.st       = ST_IDLE;
               end else begin
                  tload = 1'b1;
                  ti    = ctl_ff.tidx + 6'h01;
               end
            end
         end
      endcase
      // load the next response byte into the output register
      if (tload) begin
         rlen             = resp_len(nxt_ctl.err);
         nxt_ctl.tidx     = ti;
         nxt_ctl.tx.valid = 1'b1;
         nxt_ctl.tx.data  = resp_byte(ti, nxt_ctl.err);
         nxt_ctl.tx.last  = (ti == rlen - 6'h01);
      end
   end

   // control register, frozen while ce is low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_ff <= '0;
      end else if (ce) begin
         ctl_ff <= nxt_ctl;
      end
   end

   iocmd_byte_buf u_buf (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .clr      (clr),
      .byte_we  (byte_we),
      .byte_idx (byte_idx),
      .byte_val (rx.data),
      .word_we  (word_we),
      .word_idx (ctl_ff.idx[3:0]),
      .word_val (reg_rsp.rdata),
      .bit_we   (bit_we),
      .bit_idx  (ctl_ff.idx[7:0]),
      .bit_val  (reg_rsp.rdata[0]),
      .mem      (mem)
   );

   // handshake outputs are held off while ce is low
   always_comb begin
      rx_ready      = ce && (ctl_ff.st == ST_IDLE || ctl_ff.st == ST_RX);
      tx            = ctl_ff.tx;
      tx.valid      = ctl_ff.tx.valid && ce;
      reg_req       = ctl_ff.req;
      reg_req.valid = ctl_ff.req.valid && ce;
   end

   // checks on the interpreter behaviour
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (rst);

   a_err_top_bit: assert property (
      tx.valid && ctl_ff.tidx == 6'h00 && ctl_ff.err != 8'h00
      |-> tx.data == (ctl_ff.cmd | 8'h80))
      else $error("error response lacks flagged command");
   a_fail_code_byte: assert property (
      tx.valid && ctl_ff.tidx == 6'h01 && ctl_ff.err != 8'h00
      |-> tx.data == ctl_ff.err && tx.last)
      else $error("error code byte wrong or not last");
   a_bad_func_code: assert property (
      ce && ctl_ff.st == ST_CHECK && !cmd_legal
      |=> ctl_ff.err == 8'h01 && ctl_ff.st == ST_RESP)
      else $error("illegal command not answered with 01");
   a_addr_err_code: assert property (
      ce && ctl_ff.st == ST_EXEC && reg_req.valid && reg_rsp.ack
      && reg_rsp.err_addr |=> ctl_ff.err == 8'h02)
      else $error("address fault not coded 02");
   a_len_value_err: assert property (
      ce && ctl_ff.st == ST_CHECK && cmd_legal && cmd_wr && fits
      && {8'h00, ctl_ff.dlen} != exp_len |=> ctl_ff.err == 8'h03)
      else $error("length mismatch not coded 03");
   a_fail_err_code: assert property (
      ce && ctl_ff.st == ST_EXEC && reg_req.valid && reg_rsp.ack
      && !reg_rsp.err_addr && reg_rsp.fail |=> ctl_ff.err == 8'h04)
      else $error("device failure not coded 04");
   a_read_len_byte: assert property (
      tx.valid && ctl_ff.tidx == 6'h01 && ctl_ff.err == 8'h00 && !cmd_wr
      |-> tx.data == exp_len[7:0])
      else $error("read length byte wrong");
   a_write_echo: assert property (
      tx.valid && ctl_ff.err == 8'h00 && cmd_wr && ctl_ff.tidx == 6'h04
      |-> tx.data == ctl_ff.count[7:0] && tx.last)
      else $error("write echo count wrong");
   a_req_addr_step: assert property (
      reg_req.valid |-> reg_req.addr == ctl_ff.start + ctl_ff.idx)
      else $error("register address not start plus index");
   a_hold_big_end: assert property (
      reg_req.valid && reg_req.wr && reg_req.kind == KIND_HOLD
      |-> reg_req.wdata[15:8] == mem[{ctl_ff.idx[3:0], 4'h0} +: 8])
      else $error("holding write not msb first");
   a_coil_bit_order: assert property (
      reg_req.valid && reg_req.wr && reg_req.kind == KIND_COIL
      |-> reg_req.wdata[0] == mem[ctl_ff.idx[7:0]])
      else $error("coil bit taken from wrong position");
   a_read_decode: assert property (
      reg_req.valid && ctl_ff.cmd == 8'h04
      |-> reg_req.kind == KIND_INP && !reg_req.wr)
      else $error("input register read misdecoded");
   a_one_response: assert property (
      tx.valid && tx_ready && tx.last
      |=> ctl_ff.st == ST_IDLE && !ctl_ff.tx.valid)
      else $error("response continues after last byte");
   a_sof_restart: assert property (
      ctl_ff.st == ST_RX && rx.valid && rx.sof && rx_ready
      |=> ctl_ff.nrx == 9'h001 && ctl_ff.cmd == $past(rx.data))
      else $error("new message did not restart parsing");

   c_read_done: cover property (
      tx.valid && tx_ready && tx.last && ctl_ff.err == 8'h00 && !cmd_wr);
   c_write_done: cover property (
      tx.valid && tx_ready && tx.last && ctl_ff.err == 8'h00 && cmd_wr);
   c_error_resp: cover property (
      tx.valid && tx_ready && tx.last && ctl_ff.err != 8'h00);
   c_restart: cover property (
      ctl_ff.st == ST_RX && rx.valid && rx.sof && rx_ready);

endmodule

// [logic/iocmd_defs.svh]
`ifndef IOCMD_DEFS_SVH
`define IOCMD_DEFS_SVH

// command codes, first byte of every message
`define IOCMD_OP_RD_COIL 8'h01
`define IOCMD_OP_RD_HOLD 8'h03
`define IOCMD_OP_RD_INP  8'h04
`define IOCMD_OP_WR_COIL 8'h0F
`define IOCMD_OP_WR_HOLD 8'h10

// error flag ored into the echoed command, and error codes
`define IOCMD_ERR_FLAG  8'h80
`define IOCMD_ERR_NONE  8'h00
`define IOCMD_ERR_FUNC  8'h01
`define IOCMD_ERR_ADDR  8'h02
`define IOCMD_ERR_VALUE 8'h03
`define IOCMD_ERR_FAIL  8'h04

// byte positions inside a request
`define IOCMD_POS_DLEN  9'h005
`define IOCMD_POS_DATA  9'h006
`define IOCMD_RD_BYTES  9'h005
`define IOCMD_POS_SAT   9'h1FF

// payload buffer and register count limits
`define IOCMD_BUF_BYTES 32
`define IOCMD_BUF_LIM   9'h020
`define IOCMD_MAX_COILS 16'h0100
`define IOCMD_MAX_WORDS 16'h0010
`define IOCMD_ADDR_TOP  17'h10000

// response lengths in bytes
`define IOCMD_RESP_ERR  6'h02
`define IOCMD_RESP_WR   6'h05
`define IOCMD_RESP_HDR  6'h02

`endif

// [logic/iocmd_pkg.sv]
`include "iocmd_defs.svh"
package iocmd_pkg;

   // register class addressed by a command
   typedef enum logic [1:0] {KIND_COIL, KIND_HOLD, KIND_INP} iocmd_kind_t;

   // interpreter states
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_CHECK, ST_EXEC, ST_RESP
   } iocmd_state_t;

   // incoming command byte
   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       last;
      logic [7:0] data;
   } iocmd_rx_t;

   // outgoing response byte
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } iocmd_tx_t;

   // access to one i/o channel register
   typedef struct packed {
      logic        valid;
      logic        wr;
      iocmd_kind_t kind;
      logic [15:0] addr;
      logic [15:0] wdata;
   } iocmd_req_t;

   // answer of the i/o channel register space
   typedef struct packed {
      logic        ack;
      logic        err_addr;
      logic        fail;
      logic [15:0] rdata;
   } iocmd_rsp_t;

   // payload buffer contents
   typedef struct packed {
      logic [`IOCMD_BUF_BYTES*8-1:0] bits;
   } iocmd_buf_t;

   // interpreter control state
   typedef struct packed {
      iocmd_state_t st;
      logic [7:0]   cmd;
      logic [15:0]  start;
      logic [15:0]  count;
      logic [7:0]   dlen;
      logic [8:0]   nrx;
      logic [7:0]   err;
      logic [15:0]  idx;
      iocmd_req_t   req;
      iocmd_tx_t    tx;
      logic [5:0]   tidx;
   } iocmd_ctl_t;

endpackage

// [logic/iocmd_byte_buf.sv]
`timescale 1ns/1ps
`include "iocmd_defs.svh"
module iocmd_byte_buf (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   input  wire logic                          clr,
   input  wire logic                          byte_we,
   input  wire logic [4:0]                    byte_idx,
   input  wire logic [7:0]                    byte_val,
   input  wire logic                          word_we,
   input  wire logic [3:0]                    word_idx,
   input  wire logic [15:0]                   word_val,
   input  wire logic                          bit_we,
   input  wire logic [7:0]                    bit_idx,
   input  wire logic                          bit_val,
   output logic [`IOCMD_BUF_BYTES*8-1:0]      mem
);
   import iocmd_pkg::*;

   iocmd_buf_t store_ff;
   iocmd_buf_t nxt_store;

   // byte n sits at bits 8n+7..8n; coil k at bit k, so coils pack lsb first
   always_comb begin
      nxt_store = store_ff;
      if (clr) begin
         nxt_store.bits = '0;
      end
      if (byte_we) begin
         nxt_store.bits[{byte_idx, 3'h0} +: 8] = byte_val;
      end
      if (word_we) begin
         nxt_store.bits[{word_idx, 4'h0} +: 8] = word_val[15:8];
         nxt_store.bits[{word_idx, 4'h8} +: 8] = word_val[7:0];
      end
      if (bit_we) begin
         nxt_store.bits[bit_idx] = bit_val;
      end
   end

   // storage register, frozen while ce is low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         store_ff <= '0;
      end else if (ce) begin
         store_ff <= nxt_store;
      end
   end

   assign mem = store_ff.bits;

endmodule

// [logic/iocmd_len_calc.sv]
`timescale 1ns/1ps
`include "iocmd_defs.svh"
module iocmd_len_calc (
   input  wire iocmd_pkg::iocmd_kind_t kind,
   input  wire logic [15:0]            count,
   output logic [15:0]                 nbytes,
   output logic                        fits
);
   import iocmd_pkg::*;

   logic [16:0] coil_sum;

   // coils share packed bytes, words take two bytes each
   always_comb begin
      coil_sum = {1'b0, count} + 17'h00007;
      if (kind == KIND_COIL) begin
         nbytes = {2'h0, coil_sum[16:3]};
         fits   = (count != 16'h0000) && (count <= `IOCMD_MAX_COILS);
      end else begin
         nbytes = {count[14:0], 1'b0};
         fits   = (count != 16'h0000) && (count <= `IOCMD_MAX_WORDS);
      end
   end

endmodule

// [tb/iocmd_host.sv]
`timescale 1ns/1ps
module iocmd_host (
   input  wire logic                 mclk,
   output iocmd_pkg::iocmd_rx_t      rx,
   input  wire logic                 rx_ready,
   input  wire iocmd_pkg::iocmd_tx_t tx,
   output logic                      tx_ready
);
   import iocmd_pkg::*;
   logic slow = 1'b0;

   initial begin
      rx = '0;
      tx_ready = 1'b1;
   end

   // sink stalls every other cycle when slow is set
   always @(posedge mclk) begin
      #1 tx_ready = slow ? ~tx_ready : 1'b1;
   end

   // one message, bytes back to back, each held until taken
   task automatic send(input logic [7:0] m[$], input logic fin);
      logic rdy;
      for (int i = 0; i < m.size(); i++) begin
         rx.valid = 1'b1;
         rx.sof = (i == 0);
         rx.last = fin && (i == m.size() - 1);
         rx.data = m[i];
         do begin
            rdy = rx_ready;
            @(posedge mclk);
         end while (!rdy);
         #1;
      end
      // released data line must not keep its last value
      rx = '{1'b0, 1'b0, 1'b0, ~rx.data};
   endtask

   // collect response bytes up to the one flagged last
   task automatic recv(output logic [7:0] r[$]);
      logic done;
      r = {};
      done = 1'b0;
      for (int n = 0; n < 200 && !done; n++) begin
         @(negedge mclk);
         if (tx.valid === 1'b1 && tx_ready) begin
            r.push_back(tx.data);
            done = (tx.last === 1'b1);
         end
      end
   endtask
endmodule

// [tb/iocmd_interp_test.sv]
`timescale 1ns/1ps
module iocmd_interp_test;
   import iocmd_pkg::*;
   logic        mclk;
   logic        rst;
   logic        ce;
   iocmd_rx_t   rx;
   logic        rx_ready;
   iocmd_tx_t   tx;
   logic        tx_ready;
   iocmd_req_t  reg_req;
   iocmd_rsp_t  reg_rsp;
   logic [15:0] hmem [256];
   logic        cmem [256];
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;

   iocmd_interp u_iocmd_interp (
      .mclk     (mclk),
      .rst      (rst),
      .ce       (ce),
      .rx       (rx),
      .rx_ready (rx_ready),
      .tx       (tx),
      .tx_ready (tx_ready),
      .reg_req  (reg_req),
      .reg_rsp  (reg_rsp)
   );

   iocmd_host u_host (
      .mclk     (mclk),
      .rx       (rx),
      .rx_ready (rx_ready),
      .tx       (tx),
      .tx_ready (tx_ready)
   );

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // register space: ack one cycle after a request, fixed fault addresses
   always @(posedge mclk) begin
      #1;
      if (reg_req.valid === 1'b1 && !reg_rsp.ack) begin
         reg_rsp.ack = 1'b1;
         reg_rsp.err_addr = (reg_req.addr == 16'hEE00);
         reg_rsp.fail = (reg_req.addr == 16'hFF00);
         reg_rsp.rdata = reg_req.kind == KIND_COIL ?
            {15'h0000, cmem[reg_req.addr[7:0]]} :
            reg_req.kind == KIND_HOLD ? hmem[reg_req.addr[7:0]] :
            reg_req.addr ^ 16'h5A5A;
         if (reg_req.wr && !reg_rsp.err_addr && !reg_rsp.fail) begin
            if (reg_req.kind == KIND_COIL) begin
               cmem[reg_req.addr[7:0]] = reg_req.wdata[0];
            end else begin
               hmem[reg_req.addr[7:0]] = reg_req.wdata;
            end
         end
      end else begin
         reg_rsp.ack = 1'b0;
         reg_rsp.err_addr = 1'b0;
         reg_rsp.fail = 1'b0;
         reg_rsp.rdata = ~reg_rsp.rdata;
      end
   end

   // cut a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         $display("CHECK FAILED t=%0t timeout", $time);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // send a whole message, compare the answer, then expect silence
   task automatic run(input logic [7:0] m[$], input logic [7:0] e[$]);
      logic [7:0] r[$];
      @(posedge mclk);
      #1;
      u_host.send(m, 1'b1);
      u_host.recv(r);
      checks_done++;
      if (r.size() != e.size()) begin
         err_total++;
         $display("CHECK FAILED t=%0t length %0d", $time, r.size());
      end
      for (int i = 0; i < e.size() && i < r.size(); i++) begin
         checks_done++;
         if (r[i] !== e[i]) begin
            err_total++;
            $display("CHECK FAILED t=%0t byte %0d %h", $time, i, r[i]);
         end
      end
      repeat (3) @(negedge mclk);
      checks_done++;
      if (tx.valid !== 1'b0) begin
         err_total++;
         $display("CHECK FAILED t=%0t extra response", $time);
      end
   endtask

   task automatic t_hold;
      run('{8'h10, 8'h18, 8'h42, 8'h00, 8'h03, 8'h06, 8'h00, 8'h0A,
            8'h00, 8'h11, 8'h00, 8'h0F},
          '{8'h10, 8'h18, 8'h42, 8'h00, 8'h03});
      u_host.slow = 1'b1;
      run('{8'h03, 8'h18, 8'h42, 8'h00, 8'h03},
          '{8'h03, 8'h06, 8'h00, 8'h0A, 8'h00, 8'h11,
            8'h00, 8'h0F});
      u_host.slow = 1'b0;
   endtask

   task automatic t_coil;
      run('{8'h0F, 8'h1A, 8'h03, 8'h00, 8'h02, 8'h01, 8'h03},
          '{8'h0F, 8'h1A, 8'h03, 8'h00, 8'h02});
      run('{8'h01, 8'h1A, 8'h03, 8'h00, 8'h09},
          '{8'h01, 8'h02, 8'h03, 8'h00});
   endtask

   // clock enable low must hold off intake, then an input read
   task automatic t_input;
      @(posedge mclk);
      #1 ce = 1'b0;
      @(negedge mclk);
      checks_done++;
      if (rx_ready !== 1'b0) begin
         err_total++;
         $display("CHECK FAILED t=%0t ready while frozen", $time);
      end
      @(posedge mclk);
      #1 ce = 1'b1;
      run('{8'h04, 8'h08, 8'h66, 8'h00, 8'h01},
          '{8'h04, 8'h02, 8'h52, 8'h3C});
   endtask

   task automatic t_errors;
      run('{8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h85, 8'h01});
      run('{8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'hAA, 8'hBB,
            8'hCC}, '{8'h90, 8'h03});
      run('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h83, 8'h03});
      run('{8'h03, 8'hFF, 8'hFF, 8'h00, 8'h02}, '{8'h83, 8'h02});
      run('{8'h04, 8'hEE, 8'h00, 8'h00, 8'h01}, '{8'h84, 8'h02});
      run('{8'h10, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
          '{8'h90, 8'h04});
   endtask

   // partial message dropped by a fresh start
   task automatic t_restart;
      @(posedge mclk);
      #1;
      u_host.send('{8'h03, 8'h18}, 1'b0);
      run('{8'h04, 8'h08, 8'h66, 8'h00, 8'h01},
          '{8'h04, 8'h02, 8'h52, 8'h3C});
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_rsp = '0;
      foreach (hmem[i]) begin
         hmem[i] = 16'h0000;
         cmem[i] = 1'b0;
      end
      repeat (5) @(posedge mclk);
      #1 rst = 1'b0;
      checks_done++;
      if (rx_ready !== 1'b1 || tx.valid !== 1'b0) begin
         err_total++;
         $display("CHECK FAILED t=%0t idle after reset", $time);
      end
      t_hold();
      t_coil();
      t_input();
      t_errors();
      t_restart();
      tally_and_finish();
   end
endmodule
